/* File: src/scbcfg_pkg.sv */
package scbcfg_pkg;

  // =========================================================
  // register indices
  localparam logic [7:0] IDX_PLL = 8'h00;
  localparam logic [7:0] IDX_OEL = 8'h01;
  localparam logic [7:0] IDX_OEH = 8'h02;
  localparam logic [7:0] IDX_RSV = 8'h03;
  localparam logic [7:0] IDX_CNT = 8'h07;

  // =========================================================
  // field positions and masks
  localparam int POS_OVR = 3;
  localparam int POS_RB_LO = 6;
  localparam logic [7:0] OEL_MASK = 8'hf6;
  localparam logic [7:0] OEL_FIX = 8'h09;
  localparam logic [7:0] OEH_MASK = 8'h05;
  localparam logic [7:0] OEH_FIX = 8'h0a;
  localparam logic [7:0] CNT_MASK = 8'h1f;

  // =========================================================
  // values after reset, default target address and last bit index
  localparam logic [2:0] SW_CTL_RST = 3'h3;
  localparam logic [7:0] OEL_RST = 8'hff;
  localparam logic [7:0] OEH_RST = 8'h0f;
  localparam logic [4:0] CNT_RST = 5'h08;
  localparam logic [1:0] STRAP_MODE_RST = 2'h0;
  localparam logic FREQ_RST = 1'b0;
  localparam logic [6:0] TARGET_ADDR_DFLT = 7'h6c;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // =========================================================
  // carriers
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } scbcfg_ev_t;

  typedef struct packed {
    logic [1:0] mode;
    logic freq;
  } scbcfg_strap_t;

  typedef enum {
    ST_IDLE, ST_ADDR, ST_INDEX, ST_COUNT, ST_WDATA, ST_ACK, ST_TX, ST_HACK
  } scbcfg_state_t;

endpackage : scbcfg_pkg

/* File: src/scbcfg_bus_events.sv */
`timescale 1ns/100ps
module scbcfg_bus_events
  import scbcfg_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic clk_en, // freezes state when low
  input wire logic scl_in, // bus clock level
  input wire logic sda_in, // bus data level
  output scbcfg_ev_t ev // registered line events
);

  logic scl_q;
  logic sda_q;
  scbcfg_ev_t next_ev;

  // =========================================================
  // edge and condition detection
  // start/stop are data edges while the clock is high
  always_comb begin
    next_ev.start = scl_q & scl_in & sda_q & ~sda_in;
    next_ev.stop = scl_q & scl_in & ~sda_q & sda_in;
    next_ev.rise = ~scl_q & scl_in;
    next_ev.fall = scl_q & ~scl_in;
    next_ev.sda = sda_in;
  end

  // idle bus is high on both lines
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      ev <= '0;
    end else if (clk_en) begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      ev <= next_ev;
    end
  end

endmodule : scbcfg_bus_events

/* File: src/scbcfg_port.sv */
// Functional notes
// - write: start, address with write bit; device acknowledges matching address
// - index byte N after address is acknowledged and becomes first register
// - block write sends count byte X after index; device acknowledges it
// - X data bytes fill consecutive registers from N, each acknowledged
// - read: write address and index, repeated start, read address; acknowledged
// - device sends count byte first, then registers from N upward
// - register 0 bits 7:6 read latched bandwidth strap mode
// - register 0 bit 0 reads latched frequency strap, 1 means 100 MHz
// - register 0 bit 3 selects software mode over strap, resets 0
// - register 0 bits 2:1 hold software mode, reset to ones
// - software writes never change the latched readback bits 7:6
// - output enables in register 1 and 2 bits, all reset to one
// - enable bit 0 forces output off regardless of its pin
// - output runs only with enable bit 1 and pin low
// - writable count register is sent as the count byte of a read, default 8
`timescale 1ns/100ps
module scbcfg_port
  import scbcfg_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DFLT // arbitrary default
) (
  input wire logic ref_clk, // 20 MHz system clock
  input wire logic arst_n, // async reset, active low
  input wire logic clk_en, // freezes state when low
  input wire logic scl_in, // bus clock from host
  input wire logic sda_in, // bus data level
  output logic sda_out, // data drive value, always low
  output logic sda_oe, // high while pulling data low
  input wire logic pwrgd, // power-good, rising edge latches straps
  input wire logic [1:0] bandwidth_strap, // decoded bandwidth strap level
  input wire logic freq_strap, // frequency strap, 1 = 100 MHz
  input wire logic [7:0] out_enable_n, // per-output enable pins, active low
  output logic [7:0] out_run, // per-output run, 0 = low/low
  output logic [1:0] pll_mode, // effective PLL mode
  output logic freq_sel // latched frequency strap
);

  scbcfg_ev_t ev;
  scbcfg_state_t state, next_state, ret, next_ret;
  logic [2:0] bitcnt, next_bitcnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] ptr, next_ptr;
  logic [7:0] remain, next_remain;
  logic ack_v, next_ack_v;
  logic ack_on, next_ack_on;
  logic hack, next_hack;
  logic sda_drv, next_sda_drv;
  logic [2:0] sw_ctl, next_sw_ctl;
  logic [7:0] oel, next_oel;
  logic [7:0] oeh, next_oeh;
  logic [4:0] bcnt, next_bcnt;
  logic pwrgd_q, next_pwrgd_q;
  scbcfg_strap_t lat, next_lat;
  logic [7:0] en_vec;
  logic [7:0] next_out_run;
  logic [1:0] next_pll_mode;

  scbcfg_bus_events u_events (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(ev)
  );

  // =========================================================
  // register read view
  function automatic logic [7:0] rd_byte(input logic [7:0] idx);
    logic [7:0] r;
    r = 8'h00;
    case (idx)
      IDX_PLL: r = {lat.mode, 2'b00, sw_ctl, lat.freq};
      IDX_OEL: r = (oel & OEL_MASK) | OEL_FIX;
      IDX_OEH: r = (oeh & OEH_MASK) | OEH_FIX;
      IDX_RSV: r = 8'h00;
      IDX_CNT: r = {3'b000, bcnt};
      default: r = 8'h00;
    endcase
    return r;
  endfunction : rd_byte

  // =========================================================
  // protocol engine and register writes
  always_comb begin
    logic [7:0] b;
    logic [7:0] tx;
    b = {shreg[6:0], ev.sda};
    tx = 8'h00;
    next_state = state;
    next_ret = ret;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_ptr = ptr;
    next_remain = remain;
    next_ack_v = ack_v;
    next_ack_on = ack_on;
    next_hack = hack;
    next_sda_drv = sda_drv;
    next_sw_ctl = sw_ctl;
    next_oel = oel;
    next_oeh = oeh;
    next_bcnt = bcnt;
    if (ev.start) begin
      next_state = ST_ADDR;
      next_bitcnt = 3'h0;
      next_ack_on = 1'b0;
      next_sda_drv = 1'b0;
    end else if (ev.stop) begin
      next_state = ST_IDLE;
      next_sda_drv = 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_INDEX, ST_COUNT, ST_WDATA: begin
          if (ev.rise) begin
            next_shreg = b;
            next_bitcnt = bitcnt + 3'h1;
            if (bitcnt == LAST_BIT) begin
              next_state = ST_ACK;
              next_ack_v = 1'b1;
              case (state)
                ST_ADDR: begin
                  next_ack_v = (b[7:1] == TARGET_ADDR);
                  next_ret = b[0] ? ST_TX : ST_INDEX;
                end
                ST_INDEX: begin
                  next_ptr = b;
                  next_ret = ST_COUNT;
                end
                ST_COUNT: begin
                  next_remain = b;
                  next_ret = ST_WDATA;
                end
                default: begin
                  // bytes beyond the announced count are refused
                  next_ack_v = (remain != 8'h00);
                  next_ret = ST_WDATA;
                  if (remain != 8'h00) begin
                    next_ptr = ptr + 8'h01;
                    next_remain = remain - 8'h01;
                    case (ptr)
                      IDX_PLL: next_sw_ctl = b[POS_OVR:1];
                      IDX_OEL: next_oel = b & OEL_MASK;
                      IDX_OEH: next_oeh = b & OEH_MASK;
                      IDX_CNT: next_bcnt = b[4:0] & CNT_MASK[4:0];
                      default: next_bcnt = bcnt;
                    endcase
                  end
                end
              endcase
            end
          end
        end
        ST_ACK: begin
          if (ev.fall) begin
            if (!ack_on) begin
              next_ack_on = ack_v;
              next_sda_drv = ack_v;
              if (!ack_v) begin
                next_state = ST_IDLE;
              end
            end else begin
              next_ack_on = 1'b0;
              next_state = ret;
              next_bitcnt = 3'h0;
              if (ret == ST_TX) begin
                tx = {3'b000, bcnt};
                next_shreg = tx;
                next_sda_drv = ~tx[7];
              end else begin
                next_sda_drv = 1'b0;
              end
            end
          end
        end
        ST_TX: begin
          if (ev.fall) begin
            next_bitcnt = bitcnt + 3'h1;
            if (bitcnt == LAST_BIT) begin
              next_sda_drv = 1'b0;
              next_state = ST_HACK;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_sda_drv = ~shreg[6];
            end
          end
        end
        ST_HACK: begin
          if (ev.rise) begin
            next_hack = ~ev.sda;
          end
          if (ev.fall) begin
            if (hack) begin
              tx = rd_byte(ptr);
              next_ptr = ptr + 8'h01;
              next_shreg = tx;
              next_sda_drv = ~tx[7];
              next_bitcnt = 3'h0;
              next_state = ST_TX;
            end else begin
              next_sda_drv = 1'b0;
              next_state = ST_IDLE;
            end
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      ret <= ST_IDLE;
      bitcnt <= 3'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      remain <= 8'h00;
      ack_v <= 1'b0;
      ack_on <= 1'b0;
      hack <= 1'b0;
      sda_drv <= 1'b0;
      sw_ctl <= SW_CTL_RST;
      oel <= OEL_RST & OEL_MASK;
      oeh <= OEH_RST & OEH_MASK;
      bcnt <= CNT_RST;
    end else if (clk_en) begin
      state <= next_state;
      ret <= next_ret;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      ptr <= next_ptr;
      remain <= next_remain;
      ack_v <= next_ack_v;
      ack_on <= next_ack_on;
      hack <= next_hack;
      sda_drv <= next_sda_drv;
      sw_ctl <= next_sw_ctl;
      oel <= next_oel;
      oeh <= next_oeh;
      bcnt <= next_bcnt;
    end
  end

  // =========================================================
  // strap capture on power-good rise
  // captured once per rise, so later writes cannot disturb readback
  always_comb begin
    next_pwrgd_q = pwrgd;
    next_lat = lat;
    if (pwrgd && !pwrgd_q) begin
      next_lat.mode = bandwidth_strap;
      next_lat.freq = freq_strap;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwrgd_q <= 1'b0;
      lat <= {STRAP_MODE_RST, FREQ_RST};
    end else if (clk_en) begin
      pwrgd_q <= next_pwrgd_q;
      lat <= next_lat;
    end
  end

  // =========================================================
  // output control
  assign en_vec = {oeh[2], oeh[0], oel[7:4], oel[2:1]};

  for (genvar i = 0; i < 8; i++) begin : g_out
    assign next_out_run[i] = en_vec[i] & ~out_enable_n[i];
  end

  // new mode shows at once; the system warm-resets before relying on it
  assign next_pll_mode = sw_ctl[2] ? sw_ctl[1:0] : lat.mode;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_run <= 8'h00;
      pll_mode <= STRAP_MODE_RST;
      freq_sel <= FREQ_RST;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else if (clk_en) begin
      out_run <= next_out_run;
      pll_mode <= next_pll_mode;
      freq_sel <= lat.freq;
      sda_out <= 1'b0;
      sda_oe <= sda_drv;
    end
  end

endmodule : scbcfg_port

/* File: test/scbcfg_port_asserts.sv */
`timescale 1ns/100ps
module scbcfg_port_asserts
  import scbcfg_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic arst_n, // reset
  input wire logic clk_en, // run enable
  input wire logic scl_in, // bus clock
  input wire logic sda_in, // bus data
  input wire logic sda_out, // drive value
  input wire logic sda_oe, // pull enable
  input wire logic pwrgd, // power-good
  input wire logic [1:0] bandwidth_strap, // mode strap
  input wire logic freq_strap, // freq strap
  input wire logic [7:0] out_enable_n, // enable pins
  input wire logic [7:0] out_run, // run flags
  input wire logic [1:0] pll_mode, // mode
  input wire logic freq_sel // latched freq
);
  // ==========
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  open_drain_a: assert property (sda_out == 1'b0) else $error("data drive not low");
  sda_hold_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe)) else $error("data moved in high");
  ack_width_a: assert property ($rose(sda_oe) |-> sda_oe [*5]) else $error("pull too short");
  stop_release_a: assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> !sda_oe [*4])
    else $error("data pulled after stop");
  pin_gate_a: assert property (clk_en |=> (out_run & $past(out_enable_n)) == 8'h00)
    else $error("output runs with pin high");
  strap_latch_a: assert property ($rose(pwrgd) && $stable(freq_strap) |-> ##3 freq_sel == $past(freq_strap, 3))
    else $error("freq strap not latched");
  reset_mode_a: assert property ($rose(arst_n) |=> pll_mode == 2'h0 && freq_sel == 1'b0)
    else $error("mode wrong after reset");
  freeze_hold_a: assert property (!clk_en |=> $stable(out_run) && $stable(pll_mode) && $stable(sda_oe))
    else $error("state moved while frozen");
  // main scenarios seen
  ack_seen_c: cover property ($rose(sda_oe));
  stop_seen_c: cover property (scl_in && $rose(sda_in));
  latch_seen_c: cover property ($rose(pwrgd));
endmodule : scbcfg_port_asserts
bind scbcfg_port scbcfg_port_asserts u_asserts (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .pwrgd(pwrgd),
  .bandwidth_strap(bandwidth_strap), .freq_strap(freq_strap), .out_enable_n(out_enable_n),
  .out_run(out_run), .pll_mode(pll_mode), .freq_sel(freq_sel));

/* File: test/scbcfg_host_model.sv */
`timescale 1ns/100ps
module scbcfg_host_model #(
  parameter int PH = 5 // cycles per bus phase, above the 4 needed
) (
  input wire logic ref_clk, // system clock
  input wire logic sda, // resolved data line
  output logic scl, // bus clock
  output logic sda_lo // high pulls data low
);
  // ==========
  // line steps
  initial begin
    scl = 1'b1;
    sda_lo = 1'b0;
  end
  // one step: move lines after an edge, then hold a phase
  task automatic hold(input logic c, input logic l);
    @(posedge ref_clk);
    scl <= c;
    sda_lo <= l;
    repeat (PH) @(posedge ref_clk);
  endtask : hold
  // start or repeated start: data falls while clock high
  task automatic start();
    hold(1'b0, sda_lo);
    hold(1'b0, 1'b0);
    hold(1'b1, 1'b0);
    hold(1'b1, 1'b1);
  endtask : start
  // data rises while clock high
  task automatic stop();
    hold(1'b0, sda_lo);
    hold(1'b0, 1'b1);
    hold(1'b1, 1'b1);
    hold(1'b1, 1'b0);
  endtask : stop
  // clock falls first, data moves a phase later, so no false start
  task automatic bit_io(input logic b, output logic r);
    hold(1'b0, sda_lo);
    hold(1'b0, !b);
    hold(1'b1, !b);
    r = sda;
  endtask : bit_io
  // eight bits msb first, then the answer bit a9
  task automatic xfer(input logic [7:0] d, input logic a9, output logic [7:0] q, output logic r9);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      q[i] = b;
    end
    bit_io(a9, r9);
  endtask : xfer
endmodule : scbcfg_host_model

/* File: test/tb.sv */
`timescale 1ns/100ps
module tb;
  import scbcfg_pkg::*;
  logic ref_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, pwrgd = 1'b0, freq_strap = 1'b0;
  logic [1:0] bandwidth_strap = 2'h0, ml, pll_mode;
  logic [7:0] out_enable_n = 8'h00, q, d, out_run;
  logic [7:0] m [8];
  logic sda_out, sda_oe, scl, sda_lo, sda, a, fl, freq_sel;
  int failures = 0, comparisons = 0, seed = 32'headbe9eb;
  // ==========
  // parts
  always #25 ref_clk = ~ref_clk;
  // wired-and data line with pull-up
  assign sda = !(sda_lo || (sda_oe && !sda_out));
  scbcfg_host_model u_host (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_lo(sda_lo));
  scbcfg_port #(.TARGET_ADDR(TARGET_ADDR_DFLT)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .pwrgd(pwrgd),
    .bandwidth_strap(bandwidth_strap), .freq_strap(freq_strap), .out_enable_n(out_enable_n),
    .out_run(out_run), .pll_mode(pll_mode), .freq_sel(freq_sel));
  // ==========
  // reference model
  function automatic logic [7:0] ev(input int i);
    if (i == 0) return {ml, 2'b00, m[0][3:1], fl};
    return (i < 8) ? m[i] : 8'h00;
  endfunction : ev
  // masked writes; reserved places keep their fixed values
  function automatic void mw(input int i, input logic [7:0] v);
    case (i)
      0: m[0] = v & 8'h0e;
      1: m[1] = (v & OEL_MASK) | OEL_FIX;
      2: m[2] = (v & OEH_MASK) | OEH_FIX;
      7: m[7] = v & 8'h1f;
      default: ;
    endcase
  endfunction : mw
  function automatic logic [7:0] run_exp(input logic [7:0] p);
    return {m[2][2], m[2][0], m[1][7:4], m[1][2:1]} & ~p;
  endfunction : run_exp
  // ==========
  // tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic outs();
    repeat (3) @(posedge ref_clk);
    chk(out_run, run_exp(out_enable_n));
    chk(pll_mode, m[0][3] ? m[0][2:1] : ml);
    chk(freq_sel, fl);
  endtask : outs
  // address and index, shared by both transfer kinds
  task automatic head(input logic [7:0] n);
    u_host.start();
    u_host.xfer({TARGET_ADDR_DFLT, 1'b0}, 1'b1, q, a);
    chk(a, 1'b0);
    u_host.xfer(n, 1'b1, q, a);
    chk(a, 1'b0);
  endtask : head
  task automatic wr(input logic [7:0] n, input int x, input int extra);
    head(n);
    u_host.xfer(x[7:0], 1'b1, q, a);
    chk(a, 1'b0);
    for (int k = 0; k < x + extra; k++) begin
      d = 8'($random(seed));
      u_host.xfer(d, 1'b1, q, a);
      chk(a, k >= x);
      if (k < x) mw(n + k, d);
    end
    u_host.stop();
  endtask : wr
  task automatic rd(input logic [7:0] n, input int k);
    head(n);
    u_host.start();
    u_host.xfer({TARGET_ADDR_DFLT, 1'b1}, 1'b1, q, a);
    chk(a, 1'b0);
    u_host.xfer(8'hff, k == 0, q, a);
    chk(q, m[7]);
    for (int i = 0; i < k; i++) begin
      u_host.xfer(8'hff, i == k - 1, q, a);
      chk(q, ev(n + i));
    end
    u_host.stop();
  endtask : rd
  task automatic close_out();
    $display("counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  // ==========
  // sequence
  initial begin
    m = '{8'h06, 8'hff, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08};
    ml = 2'h0;
    fl = 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    outs();
    $display("test reset done");
    ml = 2'($random(seed));
    fl = 1'($random(seed));
    bandwidth_strap <= ml;
    freq_strap <= fl;
    out_enable_n <= 8'($random(seed));
    @(posedge ref_clk);
    pwrgd <= 1'b1;
    outs();
    rd(8'h00, int'(m[7]) + 1);
    $display("test straps done");
    for (int t = 0; t < 3; t++) begin
      wr(8'h00, 3, 1);
      out_enable_n <= 8'($random(seed));
      outs();
      rd(8'h00, 3);
    end
    $display("test writes done");
    wr(8'h03, 5, 0);
    rd(8'h01, int'(m[7]));
    rd(8'h03, 1);
    u_host.start();
    u_host.xfer({TARGET_ADDR_DFLT ^ 7'h01, 1'b0}, 1'b1, q, a);
    chk(a, 1'b1);
    u_host.stop();
    $display("test refusal done");
    d = run_exp(out_enable_n);
    clk_en <= 1'b0;
    out_enable_n <= ~out_enable_n;
    repeat (4) @(posedge ref_clk);
    chk(out_run, d);
    clk_en <= 1'b1;
    outs();
    $display("test freeze done");
    close_out();
  end
endmodule : tb
